// ===== dv/wse_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Wake sources: each fire bit makes a two cycle high pulse
// ----------------------------------------------------------------
module wse_src_model (
  input  wire logic        clk,
  input  wire logic [10:0] fire,
  output logic      [10:0] src
);
  logic [10:0] a = 11'h000;
  logic [10:0] b = 11'h000;
  // Stretch the command so the synchroniser sees a rising edge
  always @(posedge clk) begin
    a <= fire;
    b <= a;
  end
  assign src = a | b;
endmodule // wse_src_model
`default_nettype wire

// ===== dv/wse_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Register bus and wake request checks
// ----------------------------------------------------------------
module wse_sva
  import wse_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic [wse_pkg::DATA_W-1:0]  s_axi_wdata,
  input wire logic [wse_pkg::STRB_W-1:0]  s_axi_wstrb,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [ADDR_W-1:0]           s_axi_araddr,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic [wse_pkg::DATA_W-1:0]  s_axi_rdata,
  input wire logic                        wake_request_n
);
  import wse_pkg::*;
  logic [ADDR_W-1:0] aw_idx;
  logic [ADDR_W-1:0] ar_idx;
  logic              wr_both;
  // Register indices and a write taken whole at one edge
  assign aw_idx  = s_axi_awaddr >> 2;
  assign ar_idx  = s_axi_araddr >> 2;
  assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer not next cycle");
  property p_wr_lat;
    wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer not two cycles");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_busy;
    s_axi_rvalid || s_axi_bvalid |-> !s_axi_arready && !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while answer pending");
  property p_rsvd;
    s_axi_arvalid && s_axi_arready && ar_idx == ADDR_W'(IDX_RSVD) |=> s_axi_rdata == '0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved slot not zero");
  property p_unmap;
    wr_both && aw_idx == ADDR_W'(8'h30) |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped write not refused");
  property p_glb_off;
    wr_both && aw_idx == ADDR_W'(IDX_GLB_EN) && s_axi_wstrb[0] && !s_axi_wdata[0]
      |-> ##[1:3] wake_request_n;
  endproperty
  a_glb_off: assert property (p_glb_off) else $error("request kept when disabled");
  property p_rst_idle;
    $rose(rst_n) |-> wake_request_n && !s_axi_rvalid && !s_axi_bvalid;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
endmodule // wse_sva
`default_nettype wire

// ===== dv/wse_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Bench for the wake status and enable block
// ----------------------------------------------------------------
module wse_top_bench;
  import wse_pkg::*;
  logic clk, rst_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wr_rdy, bv, arr, rv, wake_n, irq;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0000, rd_data;
  logic [3:0] ws = 4'hF;
  logic [1:0] bresp, rresp;
  logic [10:0] fire = 11'h000, src;
  logic [33:0] exp_q[$];
  int n_fail = 0, tests_run = 0, cyc = 0;

  wse_src_model u_src (.clk(clk), .fire(fire), .src(src));
  wse_top #(.ADDR_W(12)) dut (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd_data), .s_axi_rresp(rresp),
    .ring_indicate_port_b(src[0]), .ring_indicate_port_a(src[1]),
    .keyboard_wake(src[2]), .mouse_wake(src[3]), .specific_key_wake(src[4]),
    .fan_speed_input_a(src[5]), .fan_speed_input_b(src[6]),
    .gpio_wake_0(src[7]), .gpio_wake_1(src[8]), .gpio_wake_2(src[9]),
    .gpio_wake_3(src[10]), .wake_request_n(wake_n), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    tests_run++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] rs = RESP_OKAY);
    logic ap, dp;
    ap = 1'b1;
    dp = 1'b1;
    exp_q.push_back({rs, 32'h0000_0000});
    awa <= {2'b00, idx, 2'b00};
    wd <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    while (ap || dp) begin
      @(posedge clk);
      if (ap && awr === 1'b1) begin
        ap = 1'b0;
        awv <= 1'b0;
      end
      if (dp && wr_rdy === 1'b1) begin
        dp = 1'b0;
        wv <= 1'b0;
      end
    end
    bry <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    bry <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] rs = RESP_OKAY);
    exp_q.push_back({rs, 24'h00_0000, d});
    ara <= {2'b00, idx, 2'b00};
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    rry <= 1'b1;
    do @(posedge clk); while (rv !== 1'b1);
    rry <= 1'b0;
  endtask

  // Pulse chosen sources, then let synchroniser and status settle
  task automatic pulse(input logic [10:0] m);
    fire <= m;
    @(posedge clk);
    fire <= 11'h000;
    repeat (8) @(posedge clk);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic wake_is(input logic v);
    repeat (2) @(posedge clk);
    check({33'h0, wake_n}, {33'h0, v});
  endtask

  // Response watcher takes the oldest expectation off the queue
  always @(posedge clk) begin
    if (rv === 1'b1 && rry === 1'b1) begin
      check({rresp, rd_data}, exp_q.pop_front());
    end
    if (bv === 1'b1 && bry === 1'b1) check({bresp, 32'h0000_0000}, exp_q.pop_front());
  end

  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    logic [6:0] m;
    logic [3:0] g;
    logic [7:0] st, p;
    void'($urandom(32'h5624));
    do_reset();
    rd(IDX_STS_A, 8'h00);
    rd(IDX_EN_C, 8'h00);
    rd(IDX_GLB_EN, 8'h00);
    m = 7'($urandom());
    g = 4'($urandom());
    pulse({g, m});
    st = {2'b00, m[4:0], 1'b0};
    rd(IDX_STS_A, st);
    rd(IDX_STS_C, {4'h0, g});
    wake_is(1'b1);
    p = 8'($urandom());
    wr(IDX_STS_A, p);
    rd(IDX_STS_A, st & ~p);
    wr(IDX_RSVD, 8'hFF);
    rd(IDX_RSVD, 8'h00);
    wr(8'h30, 8'hFF, RESP_SLVERR);
    rd(8'h30, 8'h00, RESP_SLVERR);
    wr(IDX_EN_C, 8'hFF);
    rd(IDX_EN_C, 8'h0F);
    pulse(11'h080);
    wake_is(1'b1);
    wr(IDX_GLB_EN, 8'h01);
    wake_is(1'b0);
    wr(IDX_GLB_EN, 8'h00);
    wake_is(1'b1);
    wr(IDX_GLB_EN, 8'h01);
    wr(IDX_STS_C, 8'h0F);
    wake_is(1'b1);
    wr(IDX_PIN_CTL, 8'h03);
    pulse(11'h060);
    rd(IDX_STS_A, (st & ~p) | 8'hC0);
    wr(IDX_PIN_CTL, 8'h00);
    rd(IDX_STS_A, st & ~p);
    wr(IDX_STS_A, 8'hFF);
    wr(IDX_IRQ_CLR, 8'h03);
    wr(IDX_IRQ_EN, 8'h01);
    pulse(11'h004);
    check({33'h0, irq}, 34'h1);
    wr(IDX_IRQ_CLR, 8'h01);
    wr(IDX_STS_A, 8'hFF);
    wr(IDX_IRQ_EN, 8'h00);
    check({33'h0, irq}, 34'h0);
    pulse(11'h004);
    check({33'h0, irq}, 34'h0);
    rd(IDX_IRQ_STS, 8'h01);
    do_reset();
    rd(IDX_EN_C, 8'h00);
    rd(IDX_STS_A, 8'h00);
    summarize();
  end
endmodule // wse_top_bench

bind wse_top wse_sva #(.ADDR_W(ADDR_W)) u_sva (
  .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .wake_request_n(wake_request_n)
);
`default_nettype wire

// ===== hdl/wse_event_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Wake source synchroniser with rising edge detect
// ----------------------------------------------------------------------------
module wse_event_sync #(
  parameter int WIDTH = 11
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] src,
  output logic      [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
    logic [WIDTH-1:0] rise;
  } wse_sync_s;

  wse_sync_s cur;
  wse_sync_s next_cur;

  // Two stages, then compare synced level with its delayed copy
  always_comb begin
    next_cur      = cur;
    next_cur.meta = src;
    next_cur.sync = cur.meta;
    next_cur.last = cur.sync;
    next_cur.rise = cur.sync & ~cur.last;  // One-cycle pulse per rising edge
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign rise = cur.rise;

endmodule // wse_event_sync
`default_nettype wire

// ===== hdl/wse_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// Wake status and enable: shared constants
// ----------------------------------------------------------------------------
package wse_pkg;

  // Bus widths
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_GLB_STS  = 8'h00;  // Global wake status
  localparam logic [7:0] IDX_GLB_EN   = 8'h04;  // Global wake enable
  localparam logic [7:0] IDX_STS_C    = 8'h08;  // Status for gpio wake sources
  localparam logic [7:0] IDX_STS_A    = 8'h0A;  // wake_status_group_a
  localparam logic [7:0] IDX_RSVD     = 8'h0B;  // reserved_zero_slot
  localparam logic [7:0] IDX_EN_C     = 8'h0C;  // wake_enable_group_c
  localparam logic [7:0] IDX_EN_A     = 8'h0E;  // Enables for group a sources
  localparam logic [7:0] IDX_IRQ_STS  = 8'h20;  // Sticky interrupt status
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h21;  // Interrupt clear, write only
  localparam logic [7:0] IDX_IRQ_EN   = 8'h22;  // Interrupt enable
  localparam logic [7:0] IDX_PIN_CTL  = 8'h23;  // Shared pin function select
  localparam logic [7:0] IDX_NONE     = 8'hFF;  // Marker for out-of-range address

  // Reset values, applied by the standby power-on reset only
  localparam logic       RST_GLB_STS  = 1'b0;
  localparam logic       RST_GLB_EN   = 1'b0;
  localparam logic [7:0] RST_STS_A    = 8'h00;
  localparam logic [7:0] RST_EN_A     = 8'h00;
  localparam logic [3:0] RST_STS_C    = 4'h0;
  localparam logic [3:0] RST_EN_C     = 4'h0;
  localparam logic [1:0] RST_IRQ      = 2'h0;
  localparam logic [1:0] RST_PIN_CTL  = 2'h0;

  // Group a field positions
  localparam int BIT_RING_B    = 1;
  localparam int BIT_RING_A    = 2;
  localparam int BIT_KEYBOARD  = 3;
  localparam int BIT_MOUSE     = 4;
  localparam int BIT_SPEC_KEY  = 5;
  localparam int BIT_FAN_A     = 6;
  localparam int BIT_FAN_B     = 7;
  localparam logic [7:0] MASK_A_USED = 8'hFE;  // Bit 0 reserved, reads zero

  // Pin control and interrupt field positions
  localparam int BIT_TACH_A    = 0;  // 1 = tachometer function, 0 = gpio
  localparam int BIT_TACH_B    = 1;
  localparam int BIT_IRQ_A     = 0;  // New event recorded in group a
  localparam int BIT_IRQ_C     = 1;  // New event recorded in group c

  // Number of wake source inputs
  localparam int NUM_SRC       = 11;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Bus state machine
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BRESP = 3'b010,
    ST_RRESP = 3'b100
  } wse_state_e;

endpackage : wse_pkg
`default_nettype wire

// ===== hdl/wse_top.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module wse_top
  import wse_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // AXI4-Lite write address
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [wse_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [wse_pkg::STRB_W-1:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic      [1:0]                s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  // AXI4-Lite read data
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic      [wse_pkg::DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                s_axi_rresp,
  // Wake sources, active high, asynchronous to clk
  input  wire logic                      ring_indicate_port_b,
  input  wire logic                      ring_indicate_port_a,
  input  wire logic                      keyboard_wake,
  input  wire logic                      mouse_wake,
  input  wire logic                      specific_key_wake,
  input  wire logic                      fan_speed_input_a,
  input  wire logic                      fan_speed_input_b,
  input  wire logic                      gpio_wake_0,
  input  wire logic                      gpio_wake_1,
  input  wire logic                      gpio_wake_2,
  input  wire logic                      gpio_wake_3,
  // Wake request toward the chipset and local interrupt
  output logic                           wake_request_n,
  output logic                           irq
);

  import wse_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------

  typedef struct packed {
    wse_state_e        state;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        bresp;
    logic [1:0]        rresp;
    logic              glb_sts;
    logic              glb_en;
    logic [7:0]        sts_a;
    logic [7:0]        en_a;
    logic [3:0]        sts_c;
    logic [3:0]        en_c;
    logic [1:0]        irq_sts;
    logic [1:0]        irq_en;
    logic [1:0]        pin_ctl;
    logic              wake_req;
    logic              irq;
  } wse_top_s;

  wse_top_s cur;
  wse_top_s next_cur;

  // --------------------------------------------------------------------------
  // Decode functions
  // --------------------------------------------------------------------------

  // Byte address to register index; any word index above 8'hFF gets IDX_NONE
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] word;
    word = addr >> 2;
    if ((word >> 8) != '0) begin
      return IDX_NONE;
    end else begin
      return word[7:0];
    end
  endfunction

  // True for every index that answers with OKAY
  function automatic logic is_mapped(input logic [7:0] idx);
    if (idx == IDX_GLB_STS || idx == IDX_GLB_EN || idx == IDX_STS_C) begin
      return 1'b1;
    end else if (idx == IDX_STS_A || idx == IDX_RSVD || idx == IDX_EN_C) begin
      return 1'b1;
    end else if (idx == IDX_EN_A || idx == IDX_IRQ_STS || idx == IDX_IRQ_CLR) begin
      return 1'b1;
    end else if (idx == IDX_IRQ_EN || idx == IDX_PIN_CTL) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // Read value of a register; narrow registers sit in the low bits
  function automatic logic [DATA_W-1:0] read_value(input logic [7:0] idx,
                                                   input wse_top_s s);
    logic [7:0] val;
    val = 8'h00;
    if (idx == IDX_GLB_STS) begin
      val = {7'h00, s.glb_sts};
    end else if (idx == IDX_GLB_EN) begin
      val = {7'h00, s.glb_en};
    end else if (idx == IDX_STS_C) begin
      val = {4'h0, s.sts_c};
    end else if (idx == IDX_STS_A) begin
      val = s.sts_a & MASK_A_USED;
    end else if (idx == IDX_RSVD) begin
      val = 8'h00;
    end else if (idx == IDX_EN_C) begin
      val = {4'h0, s.en_c};
    end else if (idx == IDX_EN_A) begin
      val = s.en_a & MASK_A_USED;
    end else if (idx == IDX_IRQ_STS) begin
      val = {6'h00, s.irq_sts};
    end else if (idx == IDX_IRQ_EN) begin
      val = {6'h00, s.irq_en};
    end else if (idx == IDX_PIN_CTL) begin
      val = {6'h00, s.pin_ctl};
    end else begin
      val = 8'h00;                                   // Clear register and holes
    end
    return {{(DATA_W-8){1'b0}}, val};
  endfunction

  // --------------------------------------------------------------------------
  // Wake source capture
  // --------------------------------------------------------------------------

  logic [NUM_SRC-1:0] src_level;
  logic [NUM_SRC-1:0] src_rise;

  // Bits 6:0 feed group a bits 7:1, bits 10:7 feed group c bits 3:0
  assign src_level = {gpio_wake_3, gpio_wake_2, gpio_wake_1, gpio_wake_0,
                      fan_speed_input_b, fan_speed_input_a, specific_key_wake,
                      mouse_wake, keyboard_wake, ring_indicate_port_a,
                      ring_indicate_port_b};

  wse_event_sync #(
    .WIDTH (NUM_SRC)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .src   (src_level),
    .rise  (src_rise)
  );

  // --------------------------------------------------------------------------
  // Bus handshakes
  // --------------------------------------------------------------------------

  logic       idle;
  logic       ar_take;
  logic       aw_take;
  logic       w_take;
  logic       wr_do;
  logic [7:0] wr_idx;
  logic       wr_lane;

  // Reads win in idle only when no half write is held
  assign idle          = (cur.state == ST_IDLE);
  assign s_axi_arready = idle && !cur.aw_got && !cur.w_got;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = idle && !cur.aw_got && !ar_take;
  assign s_axi_wready  = idle && !cur.w_got && !ar_take;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;

  // Write executes one cycle after both halves are taken
  assign wr_do   = idle && cur.aw_got && cur.w_got;
  assign wr_idx  = reg_index(cur.waddr);
  assign wr_lane = wr_do && cur.wstrb[0];

  // --------------------------------------------------------------------------
  // Register write strobes
  // --------------------------------------------------------------------------

  logic [7:0] wbyte;
  logic       clr_glb;
  logic [7:0] clr_a;
  logic [3:0] clr_c;
  logic [1:0] clr_irq;

  // Write-one-to-clear masks, zero unless the matching register is hit
  assign wbyte   = cur.wdata[7:0];
  assign clr_glb = (wr_lane && wr_idx == IDX_GLB_STS) ? wbyte[0] : 1'b0;
  assign clr_a   = (wr_lane && wr_idx == IDX_STS_A) ? wbyte : 8'h00;
  assign clr_c   = (wr_lane && wr_idx == IDX_STS_C) ? wbyte[3:0] : 4'h0;
  assign clr_irq = (wr_lane && wr_idx == IDX_IRQ_CLR) ? wbyte[1:0] : 2'h0;

  // --------------------------------------------------------------------------
  // Event sets
  // --------------------------------------------------------------------------

  logic [7:0] set_a;
  logic [3:0] set_c;
  logic [7:0] keep_a;

  // Every gpio edge records status regardless of any enable
  assign set_c = src_rise[10:7];

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------

  logic pend;

  // One process computes bus, register and output state
  always_comb begin
    pend     = 1'b0;
    keep_a   = MASK_A_USED;
    next_cur = cur;

    // Bus state machine
    case (cur.state)
      ST_IDLE: begin
        if (ar_take) begin
          next_cur.rdata = read_value(reg_index(s_axi_araddr), cur);
          next_cur.rresp = is_mapped(reg_index(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
          next_cur.state = ST_RRESP;
        end else if (wr_do) begin
          next_cur.bresp  = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
          next_cur.aw_got = 1'b0;
          next_cur.w_got  = 1'b0;
          next_cur.state  = ST_BRESP;
        end
        if (aw_take) begin
          next_cur.waddr  = s_axi_awaddr;
          next_cur.aw_got = 1'b1;
        end
        if (w_take) begin
          next_cur.wdata = s_axi_wdata;
          next_cur.wstrb = s_axi_wstrb;
          next_cur.w_got = 1'b1;
        end
      end
      ST_BRESP: begin
        if (s_axi_bready) begin
          next_cur.state = ST_IDLE;
        end
      end
      ST_RRESP: begin
        if (s_axi_rready) begin
          next_cur.state = ST_IDLE;
        end
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase

    // Plain read-write registers, low byte lane only
    if (wr_lane) begin
      if (wr_idx == IDX_GLB_EN) begin
        next_cur.glb_en = wbyte[0];
      end else if (wr_idx == IDX_EN_C) begin
        next_cur.en_c = wbyte[3:0];
      end else if (wr_idx == IDX_EN_A) begin
        next_cur.en_a = wbyte & MASK_A_USED;
      end else if (wr_idx == IDX_IRQ_EN) begin
        next_cur.irq_en = wbyte[1:0];
      end else if (wr_idx == IDX_PIN_CTL) begin
        next_cur.pin_ctl = wbyte[1:0];
      end
    end

    // Tach status held at zero while its pin is a gpio
    keep_a[BIT_FAN_A] = next_cur.pin_ctl[BIT_TACH_A];
    keep_a[BIT_FAN_B] = next_cur.pin_ctl[BIT_TACH_B];
    set_a             = {src_rise[6:0], 1'b0} & keep_a;

    // Sticky status, a new event wins over a clear
    next_cur.sts_a = ((cur.sts_a & ~clr_a) | set_a) & keep_a;
    next_cur.sts_c = (cur.sts_c & ~clr_c) | set_c;

    // Request is the OR of enabled status, gated globally
    pend = |(next_cur.sts_a & next_cur.en_a) ||
           |(next_cur.sts_c & next_cur.en_c);
    next_cur.wake_req = next_cur.glb_en && pend;

    // Global status is set by the request independent of the global enable, held until cleared
    next_cur.glb_sts = (cur.glb_sts && !clr_glb) || pend;

    // Local interrupt on newly recorded events
    next_cur.irq_sts[BIT_IRQ_A] = (cur.irq_sts[BIT_IRQ_A] && !clr_irq[BIT_IRQ_A]) || |set_a;
    next_cur.irq_sts[BIT_IRQ_C] = (cur.irq_sts[BIT_IRQ_C] && !clr_irq[BIT_IRQ_C]) || |set_c;
    next_cur.irq = |(next_cur.irq_sts & next_cur.irq_en);
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------

  // rst_n is the standby power-on reset; no other reset reaches these flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur.state    <= ST_IDLE;
      cur.aw_got   <= 1'b0;
      cur.w_got    <= 1'b0;
      cur.waddr    <= '0;
      cur.wdata    <= '0;
      cur.wstrb    <= '0;
      cur.rdata    <= '0;
      cur.bresp    <= RESP_OKAY;
      cur.rresp    <= RESP_OKAY;
      cur.glb_sts  <= RST_GLB_STS;
      cur.glb_en   <= RST_GLB_EN;
      cur.sts_a    <= RST_STS_A;
      cur.en_a     <= RST_EN_A;
      cur.sts_c    <= RST_STS_C;
      cur.en_c     <= RST_EN_C;
      cur.irq_sts  <= RST_IRQ;
      cur.irq_en   <= RST_IRQ;
      cur.pin_ctl  <= RST_PIN_CTL;
      cur.wake_req <= 1'b0;
      cur.irq      <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------

  // Responses and request come straight from flops
  assign s_axi_bvalid   = (cur.state == ST_BRESP);
  assign s_axi_bresp    = cur.bresp;
  assign s_axi_rvalid   = (cur.state == ST_RRESP);
  assign s_axi_rdata    = cur.rdata;
  assign s_axi_rresp    = cur.rresp;
  assign wake_request_n = !cur.wake_req;
  assign irq            = cur.irq;

endmodule // wse_top
`default_nettype wire
